// File: rtl/can_capture_pkg.sv
// Shared constants and carriers for the CAN error and arbitration capture block.
// Assumes an APB master with 32-bit data and a CAN protocol core that reports events as one-cycle pulses.
package can_capture_pkg;

   localparam logic [11:0] CAPTURE_OFFSET = 12'h000;
   localparam logic [11:0] COUNTER_OFFSET = 12'h004;
   localparam logic [11:0] CONTROL_OFFSET = 12'h008;
   localparam logic [11:0] STATUS_OFFSET = 12'h00C;

   localparam int ERR_BYTE_LSB = 0;
   localparam int ARB_BYTE_LSB = 8;
   localparam int ERR_NEW_BIT = 16;
   localparam int ARB_NEW_BIT = 17;
   localparam int TX_COUNT_LSB = 0;
   localparam int RX_COUNT_LSB = 8;
   localparam int CTRL_COMM_BIT = 0;

   localparam logic [4:0] SEG_NONE = 5'h00;
   localparam logic [4:0] SEG_ID28_21 = 5'h02;
   localparam logic [4:0] SEG_OVERLOAD = 5'h1C;
   localparam logic DIR_TX = 1'h0;
   localparam logic DIR_RX = 1'h1;
   localparam logic [1:0] TYPE_BIT = 2'h0;
   localparam logic [1:0] TYPE_FORM = 2'h1;
   localparam logic [1:0] TYPE_STUFF = 2'h2;
   localparam logic [1:0] TYPE_OTHER = 2'h3;
   localparam logic [4:0] ARB_POS_EXT_RTR = 5'h1F;

   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // Error code byte: type in 7:6, direction in 5, segment in 4:0.
   typedef struct packed {
      logic [1:0] errorType;
      logic direction;
      logic [4:0] errorSegment;
   } errorCode_s;

   typedef struct packed {
      logic valid;
      errorCode_s code;
   } errorEvent_s;

   typedef struct packed {
      logic valid;
      logic [4:0] arbLostPosition;
   } arbEvent_s;

endpackage : can_capture_pkg

// File: rtl/can_error_arb_capture.sv
// Error code and arbitration-lost capture with its APB register slave.
// Assumes event pulses synchronous to mclk from the CAN protocol core and a single APB master.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps

module can_error_arb_capture (
   input wire logic mclk, // 125 MHz system clock
   input wire logic reset_n, // asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write when high
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB transfer done
   output logic pslverr, // APB error for unmapped address
   input wire can_capture_pkg::errorEvent_s busError, // bus error pulse with its code
   input wire can_capture_pkg::arbEvent_s arbLost, // arbitration loss pulse with bit position
   output logic commActive // communication running
);

   logic rstSync1_q;
   logic rstSync2_q;
   logic rstN;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end else begin
         rstSync1_q <= 1'b1;
         rstSync2_q <= rstSync1_q;
      end
   end

   assign rstN = rstSync2_q;

   // Bus decode.
   logic accessPhase;
   logic completing;
   logic hitCapture;
   logic hitCounter;
   logic hitControl;
   logic hitStatus;
   logic hitAny;
   logic captureRead;
   logic controlWrite;

   assign accessPhase = psel & penable;
   assign completing = accessPhase & pready;
   assign hitCapture = paddr == can_capture_pkg::CAPTURE_OFFSET;
   assign hitCounter = paddr == can_capture_pkg::COUNTER_OFFSET;
   assign hitControl = paddr == can_capture_pkg::CONTROL_OFFSET;
   assign hitStatus = paddr == can_capture_pkg::STATUS_OFFSET;
   assign hitAny = hitCapture | hitCounter | hitControl | hitStatus;
   assign captureRead = completing & ~pwrite & hitCapture;
   assign controlWrite = completing & pwrite & hitControl;

   // Communication enable; a 0 to 1 write starts a fresh session.
   logic comm_q;
   logic comm_d;
   logic commStart;

   assign comm_d = controlWrite ? pwdata[can_capture_pkg::CTRL_COMM_BIT] : comm_q;
   assign commStart = comm_d & ~comm_q;

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         comm_q <= 1'b0;
      end else begin
         comm_q <= comm_d;
      end
   end

   // Events only count once communication runs.
   logic errSeen;
   logic arbSeen;

   // Segment zero never records an error.
   assign errSeen = comm_q & busError.valid & (busError.code.errorSegment != can_capture_pkg::SEG_NONE);
   assign arbSeen = comm_q & arbLost.valid;

   // The flags clear on a read only if the snapshot handed to the host showed them set; a comm start also clears them.
   // A record latched after the snapshot therefore stays new and is not lost.
   logic errShown_q;
   logic arbShown_q;
   logic errClear;
   logic arbClear;

   assign errClear = captureRead & errShown_q;
   assign arbClear = captureRead & arbShown_q;

   // Error record.
   can_capture_pkg::errorCode_s errCode_q;
   can_capture_pkg::errorCode_s errCode_d;
   logic errNew_q;
   logic errNew_d;
   logic errTake;

   assign errTake = errSeen & (~errNew_q | errClear);
   // Direction and type copied as coded.
   assign errCode_d = commStart ? '0 : (errTake ? busError.code : errCode_q);
   // Set while unreported; fields kept after clear.
   assign errNew_d = commStart ? 1'b0 : (errTake | (errNew_q & ~errClear));

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         errCode_q <= '0;
         errNew_q <= 1'b0;
      end else begin
         errCode_q <= errCode_d;
         errNew_q <= errNew_d;
      end
   end

   // Arbitration record.
   logic [4:0] arbPos_q;
   logic [4:0] arbPos_d;
   logic arbNew_q;
   logic arbNew_d;
   logic arbTake;

   assign arbTake = arbSeen & (~arbNew_q | arbClear);
   assign arbPos_d = commStart ? 5'h00 : (arbTake ? arbLost.arbLostPosition : arbPos_q);
   assign arbNew_d = commStart ? 1'b0 : (arbTake | (arbNew_q & ~arbClear));

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         arbPos_q <= 5'h00;
         arbNew_q <= 1'b0;
      end else begin
         arbPos_q <= arbPos_d;
         arbNew_q <= arbNew_d;
      end
   end

   // Error counters saturate rather than wrap, so a flood of errors cannot look like a clean bus.
   logic [7:0] txCount_q;
   logic [7:0] rxCount_q;
   logic [7:0] txCount_d;
   logic [7:0] rxCount_d;
   logic txBump;
   logic rxBump;

   function automatic logic [7:0] bumpCount(input logic [7:0] value, input logic bump);
      if (bump && value != can_capture_pkg::COUNT_MAX) begin
         bumpCount = value + 8'h01;
      end else begin
         bumpCount = value;
      end
   endfunction : bumpCount

   assign txBump = errSeen & (busError.code.direction == can_capture_pkg::DIR_TX);
   assign rxBump = errSeen & (busError.code.direction == can_capture_pkg::DIR_RX);
   assign txCount_d = commStart ? can_capture_pkg::COUNT_RESET : bumpCount(txCount_q, txBump);
   assign rxCount_d = commStart ? can_capture_pkg::COUNT_RESET : bumpCount(rxCount_q, rxBump);

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         txCount_q <= can_capture_pkg::COUNT_RESET;
         rxCount_q <= can_capture_pkg::COUNT_RESET;
      end else begin
         txCount_q <= txCount_d;
         rxCount_q <= rxCount_d;
      end
   end

   // Read data assembly; reserved bits read as zero.
   logic [31:0] captureWord;
   logic [31:0] counterWord;
   logic [31:0] controlWord;
   logic [31:0] statusWord;
   logic [31:0] readMux;

   always_comb begin
      captureWord = can_capture_pkg::WORD_ZERO;
      captureWord[can_capture_pkg::ERR_BYTE_LSB +: 8] = errCode_q;
      captureWord[can_capture_pkg::ARB_BYTE_LSB +: 5] = arbPos_q;
      captureWord[can_capture_pkg::ERR_NEW_BIT] = errNew_q;
      captureWord[can_capture_pkg::ARB_NEW_BIT] = arbNew_q;
   end

   always_comb begin
      counterWord = can_capture_pkg::WORD_ZERO;
      counterWord[can_capture_pkg::TX_COUNT_LSB +: 8] = txCount_q;
      counterWord[can_capture_pkg::RX_COUNT_LSB +: 8] = rxCount_q;
   end

   always_comb begin
      controlWord = can_capture_pkg::WORD_ZERO;
      controlWord[can_capture_pkg::CTRL_COMM_BIT] = comm_q;
      statusWord = can_capture_pkg::WORD_ZERO;
      statusWord[0] = comm_q;
      statusWord[1] = ~errNew_q;
      statusWord[2] = ~arbNew_q;
   end

   assign readMux = hitCapture ? captureWord :
                    hitCounter ? counterWord :
                    hitControl ? controlWord :
                    hitStatus ? statusWord : can_capture_pkg::WORD_ZERO;

   // One wait state: the word is sampled on the first access cycle, returned on the second.
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic snapEdge;

   assign snapEdge = accessPhase & ~pready_q;

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= can_capture_pkg::WORD_ZERO;
      end else begin
         pready_q <= snapEdge;
         pslverr_q <= snapEdge & ~hitAny;
         prdata_q <= (snapEdge & ~pwrite) ? readMux : can_capture_pkg::WORD_ZERO;
      end
   end

   // Remember which new flags the host was shown, for the re-arm decision.
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         errShown_q <= 1'b0;
         arbShown_q <= 1'b0;
      end else if (snapEdge) begin
         errShown_q <= errNew_q;
         arbShown_q <= arbNew_q;
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;
   assign commActive = comm_q;

endmodule : can_error_arb_capture

// File: test/can_core_model.sv
// Stand-in for the CAN protocol core that pulses error and arbitration events.
// Assumes its tasks are called from one bench process at a time.
`timescale 1ns/1ps
module can_core_model (
   input wire logic mclk, // clock
   output can_capture_pkg::errorEvent_s busError, // error pulse
   output can_capture_pkg::arbEvent_s arbLost // loss pulse
);
   initial begin
      busError = '0;
      arbLost = '0;
   end
   // Fields are inverted after a pulse so nothing can lean on stale data.
   task automatic sendErr(input logic [7:0] code);
      @(posedge mclk);
      busError <= {1'b1, code};
      @(posedge mclk);
      busError <= {1'b0, ~code};
   endtask : sendErr
   task automatic sendArb(input logic [4:0] pos);
      @(posedge mclk);
      arbLost <= {1'b1, pos};
      @(posedge mclk);
      arbLost <= {1'b0, ~pos};
   endtask : sendArb
endmodule : can_core_model

// File: test/can_error_arb_capture_assertions.sv
// Port-level checker for the capture block, bound to every instance of it.
// Assumes one APB master and event pulses that are synchronous to mclk.
`timescale 1ns/1ps
module can_error_arb_capture_assertions (
   input wire logic mclk, // clock
   input wire logic reset_n, // reset, active low
   input wire logic psel, // select
   input wire logic penable, // access phase
   input wire logic pwrite, // write
   input wire logic [11:0] paddr, // address
   input wire logic [31:0] pwdata, // write data
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // transfer done
   input wire logic pslverr, // transfer error
   input wire can_capture_pkg::errorEvent_s busError, // error pulse
   input wire can_capture_pkg::arbEvent_s arbLost, // loss pulse
   input wire logic commActive // running
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic errPend_q;
   logic arbPend_q;
   logic [7:0] lastErr_q;
   logic [4:0] lastArb_q;
   wire capRd = pready && !pwrite && paddr == 12'h000 && !pslverr;
   wire snap = psel && penable && !pready && !pwrite && paddr == 12'h000;
   wire restart = pready && pwrite && paddr == 12'h008 && pwdata[0] && !commActive;
   wire errEv = busError.valid && commActive && busError.code.errorSegment != 5'h00;
   // A pending event may be refused while a flag stands, so only its absence is asserted on.
   // Pending clears only on a restart or on a read that returned the flag set, as the block re-arms only then.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {errPend_q, arbPend_q, lastErr_q, lastArb_q} <= 15'h0000;
      end else if (restart) begin
         {errPend_q, arbPend_q, lastErr_q, lastArb_q} <= 15'h0000;
      end else begin
         errPend_q <= errEv || (errPend_q && !(capRd && prdata[16]));
         arbPend_q <= (arbLost.valid && commActive) || (arbPend_q && !(capRd && prdata[17]));
         lastErr_q <= capRd ? prdata[7:0] : lastErr_q;
         lastArb_q <= capRd ? prdata[12:8] : lastArb_q;
      end
   end
   AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   AST_PULSE: assert property (pready |=> !pready)
      else $error("pready held");
   AST_RESERVED: assert property (capRd |-> prdata[31:18] == 14'h0000 && prdata[15:13] == 3'h0)
      else $error("reserved bits set");
   AST_UNMAPPED: assert property (pready && paddr > 12'h00C |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access answered");
   AST_ERR_FLAG: assert property (capRd && !errPend_q |-> !prdata[16])
      else $error("error flag without event");
   AST_ARB_FLAG: assert property (capRd && !arbPend_q |-> !prdata[17])
      else $error("arbitration flag without event");
   AST_ERR_REPEAT: assert property (capRd && !prdata[16] |-> prdata[7:0] == lastErr_q)
      else $error("error byte changed without flag");
   AST_ARB_REPEAT: assert property (capRd && !prdata[17] |-> prdata[12:8] == lastArb_q)
      else $error("arbitration byte changed without flag");
   AST_SEG_SET: assert property (capRd && prdata[16] |-> prdata[4:0] != 5'h00)
      else $error("new error with empty segment");
   AST_COMM: assert property (pready && pwrite && paddr == 12'h008 |=> commActive == $past(pwdata[0]))
      else $error("comm enable not taken");
   COV_ERR: cover property (capRd && prdata[16]);
   COV_ARB: cover property (capRd && prdata[17]);
   COV_BAD: cover property (pready && pslverr);
endmodule : can_error_arb_capture_assertions

bind can_error_arb_capture can_error_arb_capture_assertions i_chk (.mclk(mclk), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .busError(busError), .arbLost(arbLost), .commActive(commActive));

// File: test/tb_can_error_arb_capture.sv
// Self-checking bench for the capture block over APB.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_can_error_arb_capture;
   logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, commActive, errSeen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   can_capture_pkg::errorEvent_s busError;
   can_capture_pkg::arbEvent_s arbLost;
   int badCount, checks, cyc;
   can_error_arb_capture i_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busError(busError),
      .arbLost(arbLost), .commActive(commActive));
   can_core_model i_core (.mclk(mclk), .busError(busError), .arbLost(arbLost));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         badCount++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("Checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         badCount++;
         conclude();
      end
   end
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask : rdchk
   task automatic tStart();
      rdchk(12'h000, 32'h0000_0000);
      i_core.sendErr(8'h42);
      apb(1'b1, 12'h008, 32'h0000_0001);
      rdchk(12'h000, 32'h0000_0000);
      rdchk(12'h004, 32'h0000_0000);
   endtask : tStart
   task automatic tCodes();
      logic [7:0] code;
      for (int s = 2; s < 29; s++) begin
         if (s inside {16, 20, 21})
            continue;
         code = {s[2:1], s[0], s[4:0]};
         i_core.sendErr(code);
         rdchk(12'h000, {14'h0000, 2'b01, 8'h00, code});
      end
      rdchk(12'h000, 32'h0000_009C);
      rdchk(12'h004, 32'h0000_0C0C);
   endtask : tCodes
   task automatic tHold();
      i_core.sendErr(8'h43);
      i_core.sendErr(8'h85);
      i_core.sendArb(5'h0C);
      rdchk(12'h000, 32'h0003_0C43);
      rdchk(12'h004, 32'h0000_0C0E);
      for (int p = 0; p < 32; p++) begin
         i_core.sendArb(p[4:0]);
         rdchk(12'h000, {14'h0000, 2'b10, 3'h0, p[4:0], 8'h43});
      end
   endtask : tHold
   task automatic tRace();
      fork
         rdchk(12'h000, 32'h0000_1F43);
         begin
            repeat (2) @(posedge mclk);
            i_core.sendErr(8'h3C);
         end
      join
      rdchk(12'h000, 32'h0001_1F3C);
   endtask : tRace
   task automatic tRefuse();
      rdchk(12'h010, 32'h0000_0000);
      check({31'h0000_0000, errSeen}, 32'h0000_0001);
      apb(1'b1, 12'h000, 32'hFFFF_FFFF);
      rdchk(12'h000, 32'h0000_1F3C);
      apb(1'b1, 12'h008, 32'h0000_0000);
      apb(1'b1, 12'h008, 32'h0000_0001);
      rdchk(12'h000, 32'h0000_0000);
      rdchk(12'h004, 32'h0000_0000);
      rdchk(12'h00C, 32'h0000_0007);
   endtask : tRefuse
   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      tStart();
      tCodes();
      tHold();
      tRace();
      tRefuse();
      conclude();
   end
endmodule : tb_can_error_arb_capture
